// ---- hdl/dspr_top.sv ----
// Local design decisions: the placing of the registers and the plain strobed port.
`include "dspr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dspr_top import dspr_pkg::*; #(
   parameter int BLANK_CYC = `DSPR_BLANK_CYC,
   parameter int NVLOAD_CYC = `DSPR_NVLOAD_CYC,
   parameter int FRAME_CYC = `DSPR_FRAME_CYC
) (
   input wire logic core_clk_in,          // Core clock, 40 MHz
   input wire logic rst_in,               // Synchronous reset, active high
   input wire logic hw_reset_n_in,        // Reset pin, active low
   input wire logic chip_select_n_in,     // Chip select pin, active low
   input wire logic serial_clk_in,        // Serial clock pin
   input wire logic cmd_data_sel_in,      // Command/data select pin
   input wire logic serial_data_in,       // Data pin input level
   input wire logic port_select_bit3_in,  // Port select strap bit 3
   input wire logic port_select_bit2_in,  // Port select strap bit 2
   input wire logic port_select_bit1_in,  // Port select strap bit 1
   input wire logic port_select_bit0_in,  // Port select strap bit 0
   input wire logic rd_en_in,             // Return a byte after the current one
   input wire logic [7:0] tx_byte_in,     // Byte to return
   input wire dspr_req_s reg_req_in,      // Register request
   output logic [31:0] reg_rdata_out,     // Register read data
   output logic serial_data_out,          // Data pin output level
   output logic serial_data_oe_out,       // Data pin output enable
   output logic serial_read_out,          // Separate read data pin
   output logic serial_read_oe_out,       // Separate read pin output enable
   output logic frame_sync_out,           // Frame sync pulse
   output logic display_blank_out,        // Display blanked
   output logic nv_load_busy_out,         // Settings load running
   output logic rx_valid_out,             // Received byte strobe
   output dspr_rx_s rx_word_out,          // Received byte and its flag
   output logic irq_out                   // Interrupt, active high
);

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   logic [8:0] sync1;
   logic [8:0] sync2;
   logic sclk_d;
   logic rst_n_s;
   logic cs_s;
   logic sclk_s;
   logic dc_s;
   logic sdi_s;
   dspr_mode_t mode_s;
   logic sclk_rise;
   logic sclk_fall;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync1 <= `DSPR_SYNC_RESET;
         sync2 <= `DSPR_SYNC_RESET;
         sclk_d <= 1'b0;
      end else begin
         sync1 <= {port_select_bit3_in, port_select_bit2_in, port_select_bit1_in,
                   port_select_bit0_in, serial_data_in, cmd_data_sel_in, serial_clk_in,
                   chip_select_n_in, hw_reset_n_in};
         sync2 <= sync1;
         sclk_d <= sync2[2];
      end
   end

   assign rst_n_s = sync2[0];
   assign cs_s = sync2[1];
   assign sclk_s = sync2[2];
   assign dc_s = sync2[3];
   assign sdi_s = sync2[4];
   assign mode_s = sync2[8:5];
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;

   // -------------------------------------------------------------------------
   // Reset spike filter
   // -------------------------------------------------------------------------
   logic [`DSPR_SPIKE_W-1:0] low_cnt;
   logic [`DSPR_SPIKE_W-1:0] high_cnt;
   logic in_reset;
   localparam logic [`DSPR_SPIKE_W-1:0] SPIKE_LAST = `DSPR_SPIKE_W'(`DSPR_SPIKE_CYC - 1);

   always_ff @(posedge core_clk_in) begin
      if (rst_in || rst_n_s) begin
         low_cnt <= '0;
      end else if (low_cnt != SPIKE_LAST) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !rst_n_s) begin
         high_cnt <= '0;
      end else if (high_cnt != SPIKE_LAST) begin
         high_cnt <= high_cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         in_reset <= 1'b0;
      end else if (!rst_n_s && low_cnt == SPIKE_LAST) begin
         in_reset <= 1'b1;
      end else if (rst_n_s && high_cnt == SPIKE_LAST) begin
         in_reset <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Reset, blanking and settings load sequence
   // -------------------------------------------------------------------------
   dspr_state_e state;
   dspr_state_e next_state;
   logic [`DSPR_CNT_W-1:0] seq_cnt;
   logic [1:0] ctrl;
   logic seq_last;

   always_comb begin
      seq_last = 1'b0;
      next_state = state;
      unique case (state)
         DSPR_ST_RUN: begin
            if (in_reset) begin
               next_state = ctrl[`DSPR_CTRL_SLEEP] ? DSPR_ST_HELD : DSPR_ST_BLANK;
            end
         end
         DSPR_ST_BLANK: begin
            seq_last = (seq_cnt == `DSPR_CNT_W'(BLANK_CYC - 1));
            if (seq_last) begin
               next_state = DSPR_ST_HELD;
            end
         end
         DSPR_ST_HELD: begin
            if (!in_reset) begin
               next_state = DSPR_ST_LOAD;
            end
         end
         DSPR_ST_LOAD: begin
            seq_last = (seq_cnt == `DSPR_CNT_W'(NVLOAD_CYC - 1));
            if (in_reset) begin
               next_state = DSPR_ST_HELD;
            end else if (seq_last) begin
               next_state = DSPR_ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state <= DSPR_ST_LOAD;
         seq_cnt <= '0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            seq_cnt <= '0;
         end else if (!seq_last) begin
            seq_cnt <= seq_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         display_blank_out <= 1'b1;
         nv_load_busy_out <= 1'b1;
      end else begin
         display_blank_out <= (next_state != DSPR_ST_RUN);
         nv_load_busy_out <= (next_state == DSPR_ST_LOAD);
      end
   end

   // -------------------------------------------------------------------------
   // Serial receive
   // -------------------------------------------------------------------------
   logic mode_3w;
   logic mode_4w2;
   logic rx_on;
   logic [2:0] bit_cnt;
   logic [7:0] rx_sh;
   logic byte_end;

   assign mode_3w = (mode_s == `DSPR_MODE_3W);
   assign mode_4w2 = (mode_s == `DSPR_MODE_4W2);
   assign rx_on = (state == DSPR_ST_RUN) && (mode_3w || mode_4w2) && !cs_s;
   assign byte_end = rx_on && sclk_rise && (bit_cnt == 3'h7);

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !rx_on) begin
         bit_cnt <= '0;
         rx_sh <= '0;
      end else if (sclk_rise) begin
         bit_cnt <= bit_cnt + 1'b1;
         rx_sh <= {rx_sh[6:0], sdi_s};
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rx_valid_out <= 1'b0;
         rx_word_out <= '0;
      end else begin
         rx_valid_out <= byte_end;
         if (byte_end) begin
            rx_word_out.byte_v <= {rx_sh[6:0], sdi_s};
            rx_word_out.is_data <= dc_s;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Serial transmit
   // -------------------------------------------------------------------------
   logic [7:0] tx_sh;
   logic [3:0] tx_left;
   logic tx_bit;
   logic tx_drive;

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !rx_on) begin
         tx_sh <= '0;
         tx_left <= '0;
         tx_drive <= 1'b0;
      end else if (byte_end && rd_en_in) begin
         tx_sh <= tx_byte_in;
         tx_left <= 4'h8;
      end else if (sclk_fall) begin
         tx_drive <= (tx_left != 4'h0);
         if (tx_left != 4'h0) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
            tx_left <= tx_left - 1'b1;
         end
      end
   end

   // Output bit holds between falling edges so it is stable at the host's sample
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         tx_bit <= 1'b0;
      end else if (rx_on && sclk_fall && tx_left != 4'h0) begin
         tx_bit <= tx_sh[7];
      end
   end

   assign serial_data_out = tx_bit;
   assign serial_read_out = tx_bit;
   assign serial_data_oe_out = tx_drive && mode_3w;
   assign serial_read_oe_out = tx_drive && mode_4w2;

   // -------------------------------------------------------------------------
   // Frame sync generator
   // -------------------------------------------------------------------------
   logic [`DSPR_CNT_W-1:0] frame_cnt;
   logic [2:0] te_left;
   logic frame_start;

   assign frame_start = (state == DSPR_ST_RUN) && (frame_cnt == '0);

   always_ff @(posedge core_clk_in) begin
      if (rst_in || state != DSPR_ST_RUN) begin
         frame_cnt <= '0;
      end else if (frame_cnt == `DSPR_CNT_W'(FRAME_CYC - 1)) begin
         frame_cnt <= '0;
      end else begin
         frame_cnt <= frame_cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         te_left <= '0;
         frame_sync_out <= 1'b0;
      end else begin
         if (frame_start && ctrl[`DSPR_CTRL_TE_EN]) begin
            te_left <= 3'(`DSPR_TE_CYC);
         end else if (te_left != 3'h0) begin
            te_left <= te_left - 1'b1;
         end
         frame_sync_out <= (te_left != 3'h0);
      end
   end

   // -------------------------------------------------------------------------
   // Registers and interrupt
   // -------------------------------------------------------------------------
   logic [`DSPR_EV_W-1:0] status;
   logic [`DSPR_EV_W-1:0] enable;
   logic [`DSPR_EV_W-1:0] events;
   logic [`DSPR_EV_W-1:0] clr;
   logic in_reset_d;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         in_reset_d <= 1'b0;
      end else begin
         in_reset_d <= in_reset;
      end
   end

   always_comb begin
      events = '0;
      events[`DSPR_EV_RX] = byte_end;
      events[`DSPR_EV_RESET] = in_reset && !in_reset_d;
      events[`DSPR_EV_LOADED] = (state == DSPR_ST_LOAD) && (next_state == DSPR_ST_RUN);
      events[`DSPR_EV_FRAME] = frame_start;
      clr = '0;
      if (reg_req_in.wr && reg_req_in.addr == `DSPR_REG_CLEAR) begin
         clr = reg_req_in.wdata[`DSPR_EV_W-1:0];
      end
   end

   // Set beats clear in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         status <= '0;
      end else begin
         status <= (status & ~clr) | events;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         enable <= '0;
      end else if (reg_req_in.wr && reg_req_in.addr == `DSPR_REG_ENABLE) begin
         enable <= reg_req_in.wdata[`DSPR_EV_W-1:0];
      end
   end

   // Hardware reset returns control to its default condition
   always_ff @(posedge core_clk_in) begin
      if (rst_in || in_reset) begin
         ctrl <= `DSPR_CTRL_RESET;
      end else if (reg_req_in.wr && reg_req_in.addr == `DSPR_REG_CTRL) begin
         ctrl <= reg_req_in.wdata[1:0];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !reg_req_in.rd) begin
         reg_rdata_out <= '0;
      end else begin
         unique case (reg_req_in.addr)
            `DSPR_REG_STATUS: reg_rdata_out <= {28'h0, status};
            `DSPR_REG_ENABLE: reg_rdata_out <= {28'h0, enable};
            `DSPR_REG_CTRL: reg_rdata_out <= {30'h0, ctrl};
            `DSPR_REG_STATE: reg_rdata_out <= {23'h0, mode_s, state, in_reset};
            default: reg_rdata_out <= '0;
         endcase
      end
   end

   assign irq_out = |(status & enable);

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   sequence te_pulse_s;
      frame_sync_out [*4] ##1 !frame_sync_out;
   endsequence

   sequence hold_release_s;
      (state == DSPR_ST_HELD) && !in_reset;
   endsequence

   reset_filter_a: assert property ($rose(in_reset) |-> $past(low_cnt) == SPIKE_LAST)
      else $error("reset taken before the spike time");
   short_spike_a: assert property (!rst_n_s && low_cnt < SPIKE_LAST |=> !$rose(in_reset))
      else $error("short reset pulse accepted");
   glitch_hold_a: assert property ($fell(in_reset) |-> $past(high_cnt) == SPIKE_LAST)
      else $error("reset released by a glitch");
   nv_restart_a: assert property (hold_release_s |=> state == DSPR_ST_LOAD ##1 nv_load_busy_out)
      else $error("settings load not restarted");
   blank_reset_a: assert property (in_reset |=> display_blank_out)
      else $error("display not blanked in reset");
   sdo_fall_a: assert property ($changed(tx_bit) |-> $past(sclk_fall))
      else $error("read bit changed off a falling edge");
   rx_rise_a: assert property (rx_valid_out |-> $past(sclk_rise) && !$past(cs_s))
      else $error("byte completed without a rising edge");
   cs_ignore_a: assert property (cs_s |=> bit_cnt == 3'h0 && !rx_valid_out)
      else $error("serial activity while deselected");
   dc_take_a: assert property (rx_valid_out |-> rx_word_out.is_data == $past(dc_s))
      else $error("command flag not taken with last bit");
   pin_mode_a: assert property (serial_data_oe_out |-> mode_3w && !serial_read_oe_out)
      else $error("data pin driven outside shared mode");
   sdo_mode_a: assert property (serial_read_oe_out |-> mode_4w2)
      else $error("read pin driven outside split mode");
   te_width_a: assert property ($rose(frame_sync_out) |-> te_pulse_s)
      else $error("frame sync pulse width wrong");

endmodule

`default_nettype wire

// ---- hdl/dspr_cfg.svh ----
`ifndef DSPR_CFG_SVH
`define DSPR_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define DSPR_CLK_MHZ 40
`define DSPR_SPIKE_US 5
`define DSPR_SPIKE_CYC (`DSPR_SPIKE_US * `DSPR_CLK_MHZ)
`define DSPR_BLANK_MS 120
`define DSPR_BLANK_CYC (`DSPR_BLANK_MS * 1000 * `DSPR_CLK_MHZ)
`define DSPR_NVLOAD_MS 100
`define DSPR_NVLOAD_CYC (`DSPR_NVLOAD_MS * 1000 * `DSPR_CLK_MHZ)
`define DSPR_FRAME_US 16667
`define DSPR_FRAME_CYC (`DSPR_FRAME_US * `DSPR_CLK_MHZ)
`define DSPR_TE_CYC 4
`define DSPR_SPIKE_W 8
`define DSPR_CNT_W 23

// ----------------------------------------------------------------------------
// Port select codes, highest bit first
// ----------------------------------------------------------------------------
`define DSPR_MODE_3W 4'h6
`define DSPR_MODE_4W2 4'he

// ----------------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------------
`define DSPR_REG_STATUS 8'h00
`define DSPR_REG_CLEAR 8'h04
`define DSPR_REG_ENABLE 8'h08
`define DSPR_REG_CTRL 8'h0c
`define DSPR_REG_STATE 8'h10
`define DSPR_EV_W 4
`define DSPR_EV_RX 0
`define DSPR_EV_RESET 1
`define DSPR_EV_LOADED 2
`define DSPR_EV_FRAME 3
`define DSPR_CTRL_SLEEP 0
`define DSPR_CTRL_TE_EN 1
`define DSPR_CTRL_RESET 2'h1
`define DSPR_SYNC_RESET 9'h003

`endif

// ---- hdl/dspr_pkg.sv ----
package dspr_pkg;

   typedef enum logic [3:0] {
      DSPR_ST_RUN   = 4'b0001,
      DSPR_ST_BLANK = 4'b0010,
      DSPR_ST_HELD  = 4'b0100,
      DSPR_ST_LOAD  = 4'b1000
   } dspr_state_e;

   typedef struct packed {
      logic is_data;
      logic [7:0] byte_v;
   } dspr_rx_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dspr_req_s;

   typedef logic [3:0] dspr_mode_t;

endpackage

// ---- tb/dspr_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module dspr_host (
   input wire logic clk_in,         // Core clock used for pacing
   input wire logic miso_in,        // Pin level that carries read data
   output logic chip_select_n_out,  // Chip select, active low
   output logic sclk_out,           // Serial clock, idle low
   output logic cmd_data_sel_out,   // Command/data select
   output logic sda_out             // Data pin drive level
);
   // ----
   // Host side of the serial port, 8 core cycles a bit
   // ----
   logic drive;

   initial begin
      chip_select_n_out = 1'b1;
      sclk_out = 1'b0;
      cmd_data_sel_out = 1'b0;
      sda_out = 1'b0;
      drive = 1'b1;
   end

   // Released pin shows no stale level
   always @(posedge clk_in) begin
      if (!drive) begin
         sda_out <= ~sda_out;
      end
   end

   task automatic open_frame();
      @(posedge clk_in);
      chip_select_n_out <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   task automatic close_frame();
      @(posedge clk_in);
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      chip_select_n_out <= 1'b1;
      drive <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask

   task automatic xfer(input logic dc, input logic [7:0] b, input logic rel, input int nbits,
                       output logic [7:0] got);
      got = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         @(posedge clk_in);
         sclk_out <= 1'b0;
         drive <= ~rel;
         if (!rel) begin
            sda_out <= b[i];
         end
         cmd_data_sel_out <= dc;
         repeat (3) @(posedge clk_in);
         @(negedge clk_in);
         got[i] = miso_in;
         @(posedge clk_in);
         sclk_out <= 1'b1;
         repeat (3) @(posedge clk_in);
      end
   endtask
endmodule

`default_nettype wire

// ---- tb/test_display_serial_port_reset.sv ----
`include "dspr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s expected %h seen %h", n, e, g); end end

module test_display_serial_port_reset import dspr_pkg::*; ();
   // ----
   // Bench signals
   // ----
   logic clk = 1'b0, rst = 1'b1, hw_n = 1'b1, rd_en = 1'b0;
   logic [3:0] mode = `DSPR_MODE_3W;
   logic [7:0] tx = 8'h00;
   dspr_req_s req = '0;
   logic [31:0] rdata;
   logic sd_o, sd_oe, sr_o, sr_oe, fsync, blank, busy, rxv, irq;
   logic h_cs_n, h_sclk, h_dcx, h_sda, pin, miso;
   dspr_rx_s rxw;
   dspr_rx_s rx_log [0:7];
   int miscompares = 0, checks = 0, rx_cnt = 0, od = 0, orr = 0;

   always #12.5 clk = ~clk;
   assign pin = sd_oe ? sd_o : h_sda;
   assign miso = (mode == `DSPR_MODE_4W2) ? (sr_oe ? sr_o : ~sr_o) : pin;

   always @(posedge clk) begin
      if (rxv === 1'b1) begin
         rx_log[rx_cnt[2:0]] <= rxw;
         rx_cnt <= rx_cnt + 1;
      end
      od <= od + int'(sd_oe === 1'b1);
      orr <= orr + int'(sr_oe === 1'b1);
   end

   dspr_top #(.BLANK_CYC(50), .NVLOAD_CYC(40), .FRAME_CYC(200)) dut (
      .core_clk_in(clk), .rst_in(rst), .hw_reset_n_in(hw_n), .chip_select_n_in(h_cs_n),
      .serial_clk_in(h_sclk), .cmd_data_sel_in(h_dcx), .serial_data_in(pin),
      .port_select_bit3_in(mode[3]), .port_select_bit2_in(mode[2]),
      .port_select_bit1_in(mode[1]), .port_select_bit0_in(mode[0]),
      .rd_en_in(rd_en), .tx_byte_in(tx), .reg_req_in(req), .reg_rdata_out(rdata),
      .serial_data_out(sd_o), .serial_data_oe_out(sd_oe), .serial_read_out(sr_o),
      .serial_read_oe_out(sr_oe), .frame_sync_out(fsync), .display_blank_out(blank),
      .nv_load_busy_out(busy), .rx_valid_out(rxv), .rx_word_out(rxw), .irq_out(irq));

   dspr_host host (.clk_in(clk), .miso_in(miso), .chip_select_n_out(h_cs_n),
      .sclk_out(h_sclk), .cmd_data_sel_out(h_dcx), .sda_out(h_sda));

   // ----
   // Helpers
   // ----
   task automatic stop_test();
      if (miscompares == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   function automatic logic pick(input int s);
      return (s == 0) ? busy : (s == 1) ? fsync : blank;
   endfunction

   task automatic wait_for(input int s, input logic lvl, input int lim);
      int n;
      n = 0;
      while (pick(s) !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
      if (pick(s) !== lvl) begin
         miscompares++;
         $display("BAD wait expected %h seen %h", lvl, pick(s));
         stop_test();
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      d = rdata;
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_boot();
      logic [31:0] d;
      `CHK("blank", 1'b1, blank)
      `CHK("busy", 1'b1, busy)
      wait_for(0, 1'b0, 100);
      @(negedge clk);
      `CHK("blank", 1'b0, blank)
      reg_rd(`DSPR_REG_CTRL, d);
      `CHK("ctrl", 32'h1, d)
      reg_rd(8'h20, d);
      `CHK("unmapped", 32'h0, d)
      reg_rd(`DSPR_REG_STATUS, d);
      `CHK("loaded", 1'b1, d[`DSPR_EV_LOADED])
   endtask

   task automatic t_write();
      logic [7:0] g;
      logic [31:0] d;
      int c;
      @(posedge clk);
      mode <= `DSPR_MODE_3W;
      reg_wr(`DSPR_REG_ENABLE, 32'h1);
      c = rx_cnt;
      host.open_frame();
      host.xfer(1'b0, 8'h2c, 1'b0, 8, g);
      host.xfer(1'b1, 8'ha5, 1'b0, 8, g);
      host.close_frame();
      `CHK("rx_count", c + 2, rx_cnt)
      `CHK("cmd", 9'h02c, rx_log[c[2:0]])
      `CHK("data", 9'h1a5, rx_log[c[2:0] + 3'h1])
      `CHK("irq", 1'b1, irq)
      reg_wr(`DSPR_REG_ENABLE, 32'h0);
      @(negedge clk);
      `CHK("irq_masked", 1'b0, irq)
      reg_wr(`DSPR_REG_CLEAR, 32'hf);
      reg_rd(`DSPR_REG_STATUS, d);
      `CHK("status", 1'b0, d[`DSPR_EV_RX])
      host.open_frame();
      host.xfer(1'b1, 8'hff, 1'b0, 3, g);
      host.close_frame();
      host.open_frame();
      host.xfer(1'b1, 8'h3c, 1'b0, 8, g);
      host.close_frame();
      `CHK("rx_count", c + 3, rx_cnt)
      `CHK("after_abort", 9'h13c, rx_log[c[2:0] + 3'h2])
   endtask

   task automatic t_read(input logic [3:0] m, input logic [7:0] b);
      logic [7:0] g;
      int d0, r0;
      @(posedge clk);
      mode <= m;
      rd_en <= 1'b1;
      tx <= b;
      host.open_frame();
      host.xfer(1'b0, 8'h0b, 1'b0, 8, g);
      repeat (4) @(posedge clk);
      rd_en <= 1'b0;
      d0 = od;
      r0 = orr;
      host.xfer(1'b0, 8'h00, m == `DSPR_MODE_3W, 8, g);
      host.close_frame();
      `CHK("read_byte", b, g)
      `CHK("shared_oe", m == `DSPR_MODE_3W, od > d0)
      `CHK("split_oe", m == `DSPR_MODE_4W2, orr > r0)
      `CHK("oe_off", 2'b00, {sd_oe, sr_oe})
   endtask

   task automatic t_frame();
      int n;
      reg_wr(`DSPR_REG_CTRL, 32'h2);
      wait_for(1, 1'b1, 300);
      n = 0;
      while (fsync === 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      `CHK("sync_len", `DSPR_TE_CYC, n)
   endtask

   task automatic t_hwreset();
      logic [31:0] d;
      @(posedge clk);
      hw_n <= 1'b0;
      repeat (100) @(posedge clk);
      hw_n <= 1'b1;
      repeat (150) @(posedge clk);
      `CHK("spike_blank", 1'b0, blank)
      reg_rd(`DSPR_REG_STATUS, d);
      `CHK("spike_seen", 1'b0, d[`DSPR_EV_RESET])
      @(posedge clk);
      hw_n <= 1'b0;
      wait_for(2, 1'b1, 360);
      repeat (20) @(posedge clk);
      hw_n <= 1'b1;
      repeat (50) @(posedge clk);
      hw_n <= 1'b0;
      `CHK("glitch_busy", 1'b0, busy)
      repeat (100) @(posedge clk);
      `CHK("held_blank", 1'b1, blank)
      hw_n <= 1'b1;
      wait_for(0, 1'b1, 300);
      `CHK("load_blank", 1'b1, blank)
      wait_for(0, 1'b0, 100);
      reg_rd(`DSPR_REG_CTRL, d);
      `CHK("ctrl_default", 32'h1, d)
      reg_rd(`DSPR_REG_STATUS, d);
      `CHK("reset_seen", 1'b1, d[`DSPR_EV_RESET])
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_boot();
      t_write();
      t_read(`DSPR_MODE_3W, 8'h96);
      t_read(`DSPR_MODE_4W2, 8'h69);
      t_frame();
      t_hwreset();
      stop_test();
   end
endmodule

`default_nettype wire
